// ### shared/secp_pkg.sv
package secp_pkg;
    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int BYTE_COUNT     = 256;
    localparam int BYTE_ADDR_BITS = 8;
    localparam int WORD_ADDR_BITS = 7;
    localparam int BYTE_DATA_BITS = 8;
    localparam int WORD_DATA_BITS = 16;
    localparam int OPCODE_BITS    = 4;
    localparam logic [7:0] ERASED_BYTE = 8'h0_0FF;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_READ         = 4'h8;
    localparam logic [2:0] OPC_PROGRAM_LOW  = 3'h4;
    localparam logic [3:0] OPC_PROGRAM_EN   = 4'h3;
    localparam logic [3:0] OPC_PROGRAM_DIS  = 4'h0;
    localparam logic [3:0] OPC_ERASE_ALL    = 4'h2;
    localparam logic [3:0] OPC_WRITE_ALL    = 4'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ              = 10_000_000;
    localparam int PROGRAMMING_TIME_MS = 10;
    localparam int PROGRAMMING_CYCLES  = (CLK_HZ / 1000) * PROGRAMMING_TIME_MS;
    localparam int TIMER_BITS          = 17;

    // ------------------------------------------------------------
    // Queued array operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_PROGRAM,
        KIND_ERASE_ALL,
        KIND_WRITE_ALL
    } secp_kind_e;

    typedef struct packed {
        logic       word_org;
        secp_kind_e kind;
        logic [7:0] addr;
        logic [15:0] data;
    } secp_cmd_s;

    localparam int CMD_BITS = $bits(secp_cmd_s);
endpackage

// ### shared/secp_cmd_if.sv
`timescale 1ns/100ps
interface secp_cmd_if #(
    parameter int WIDTH = 27
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] payload;

    modport source (output valid, output payload, input ready);
    modport sink   (input valid, input payload, output ready);
endinterface

// ### hw/secp_cmd_buffer.sv
`timescale 1ns/100ps
module secp_cmd_buffer #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic   clk_in,
    input  wire logic   resetn_in,
    // Filling and draining sides
    secp_cmd_if.sink    up,
    secp_cmd_if.source  dn
);
    localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0]  store_r [DEPTH];
    logic [PTR_BITS-1:0] wr_ptr_r;
    logic [PTR_BITS-1:0] rd_ptr_r;
    logic [PTR_BITS:0]   fill_r;
    logic                push;
    logic                pop;

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    assign up.ready   = (fill_r != (PTR_BITS+1)'(DEPTH));
    assign dn.valid   = (fill_r != '0);
    assign dn.payload = store_r[rd_ptr_r];
    assign push       = up.valid && up.ready;
    assign pop        = dn.valid && dn.ready;

    function automatic logic [PTR_BITS-1:0] step(input logic [PTR_BITS-1:0] p);
        return (p == PTR_BITS'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (push) begin
            store_r[wr_ptr_r] <= up.payload;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r   <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= step(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= step(rd_ptr_r);
            end
            if (push && !pop) begin
                fill_r <= fill_r + 1'b1;
            end else if (pop && !push) begin
                fill_r <= fill_r - 1'b1;
            end
        end
    end
endmodule

// ### hw/secp_command_port.sv
`timescale 1ns/100ps
// Behaviour
// [R1] Strap high gives 128 x 16 words, strap low gives 256 x 8 bytes.
// [R2] Instruction is start bit, 4-bit opcode, 8 or 7 address bits.
// [R3] Opcode 1000 loads addressed word into output shifter; only read drives out.
// [R4] Read sends one 0 dummy bit, then data most significant first.
// [R5] Serial output changes only right after a rising serial clock edge.
// [R6] Host follows program address with 8 or 16 data bits.
// [R7] After the last data bit the location is erased then written, self-timed.
// [R8] Ready is low for the whole programming time, at most 10 ms; here it stays low until every queued operation has finished.
// [R9] Programming all ones leaves the location erased.
// [R10] Programming refused until program enable, then allowed until disable.
// [R11] Program disable clears permission; program and bulk writes then ignored.
// [R12] Reads work whether programming is enabled or not.
// [R13] Opcode 0010 with zero address erases the whole array.
// [R14] Opcode 0001 plus one data word writes it to every location.
// [R15] Host erases the array before write-all; write-all only clears bits.
// [R16] After write-all, ready stays low until every bit is final.
// [R17] Host keeps the last address bit low during the dummy bit.
// [R18] Serial input sampled on rising edges; chip select low abandons the instruction.
// [R19] Activity before the start bit is ignored; first 1 starts an instruction.
module secp_command_port #(
    parameter int PROG_CYCLES = secp_pkg::PROGRAMMING_CYCLES
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic resetn_in,
    // Serial link pins
    input  wire logic chip_select_in,
    input  wire logic serial_clk_in,
    input  wire logic serial_in,
    output logic      serial_out_out,
    output logic      serial_out_oe_out,
    // Strap and status
    input  wire logic organisation_strap_in,
    output logic      ready_out
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_DATA,
        ST_READ,
        ST_HOLD
    } secp_state_e;

    typedef enum logic [1:0] {
        EX_IDLE,
        EX_SWEEP,
        EX_WAIT
    } secp_exec_e;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_sync_r;
    logic [1:0] sclk_sync_r;
    logic [1:0] din_sync_r;
    logic [1:0] org_sync_r;
    logic       sclk_last_r;
    logic       cs;
    logic       din;
    logic       sclk_rise;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cs_sync_r   <= 2'h0;
            sclk_sync_r <= 2'h0;
            din_sync_r  <= 2'h0;
            org_sync_r  <= 2'h3;
            sclk_last_r <= 1'b0;
        end else begin
            cs_sync_r   <= {cs_sync_r[0], chip_select_in};
            sclk_sync_r <= {sclk_sync_r[0], serial_clk_in};
            din_sync_r  <= {din_sync_r[0], serial_in};
            org_sync_r  <= {org_sync_r[0], organisation_strap_in};
            sclk_last_r <= sclk_sync_r[1];
        end
    end

    assign cs        = cs_sync_r[1];
    assign din       = din_sync_r[1];
    assign sclk_rise = sclk_sync_r[1] && !sclk_last_r; // [R18]

    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    logic [7:0] mem_r [secp_pkg::BYTE_COUNT];

    function automatic logic [15:0] fetch(input logic word_org, input logic [7:0] a);
        logic [15:0] w;
        w = 16'h0_000;
        if (word_org) begin
            w = {mem_r[{a[6:0], 1'b0}], mem_r[{a[6:0], 1'b1}]};
        end else begin
            w = {mem_r[a], 8'h00};
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // Instruction shifter
    // ------------------------------------------------------------
    secp_state_e        state_r;
    logic               word_org_r;
    logic [4:0]         cnt_r;
    logic [3:0]         opc_r;
    logic [7:0]         addr_r;
    logic [15:0]        data_r;
    logic [15:0]        out_sr_r;
    logic               prog_en_r;
    secp_pkg::secp_kind_e kind_r;
    logic               cmd_valid_r;
    secp_pkg::secp_cmd_s  cmd_r;
    logic [7:0]         addr_nxt;
    logic [15:0]        data_nxt;
    logic [4:0]         addr_len;
    logic [4:0]         data_len;

    secp_cmd_if #(.WIDTH(secp_pkg::CMD_BITS)) fill_if ();
    secp_cmd_if #(.WIDTH(secp_pkg::CMD_BITS)) drain_if ();

    assign addr_nxt = word_org_r ? {1'b0, addr_r[5:0], din} : {addr_r[6:0], din};
    assign data_nxt = {data_r[14:0], din};
    assign addr_len = word_org_r ? 5'(secp_pkg::WORD_ADDR_BITS) : 5'(secp_pkg::BYTE_ADDR_BITS); // [R2]
    assign data_len = word_org_r ? 5'(secp_pkg::WORD_DATA_BITS) : 5'(secp_pkg::BYTE_DATA_BITS); // [R6]

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r           <= ST_IDLE;
            word_org_r        <= 1'b1;
            cnt_r             <= 5'h0_0;
            opc_r             <= 4'h0;
            addr_r            <= 8'h00;
            data_r            <= 16'h0_000;
            out_sr_r          <= 16'h0_000;
            prog_en_r         <= 1'b0;
            kind_r            <= secp_pkg::KIND_PROGRAM;
            cmd_valid_r       <= 1'b0;
            cmd_r             <= '0;
            serial_out_out    <= 1'b0;
            serial_out_oe_out <= 1'b0;
        end else begin
            cmd_valid_r <= 1'b0;
            if (!cs) begin
                state_r           <= ST_IDLE; // [R18]
                serial_out_oe_out <= 1'b0;
                serial_out_out    <= 1'b0;
            end else if (sclk_rise) begin
                case (state_r)
                    ST_IDLE: begin
                        if (din) begin
                            state_r    <= ST_OPCODE; // [R19]
                            word_org_r <= org_sync_r[1]; // [R1]
                            cnt_r      <= 5'h0_0;
                        end
                    end
                    ST_OPCODE: begin
                        opc_r <= {opc_r[2:0], din};
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r == 5'(secp_pkg::OPCODE_BITS - 1)) begin
                            state_r <= ST_ADDR; // [R2]
                            cnt_r   <= 5'h0_0;
                            addr_r  <= 8'h00;
                        end
                    end
                    ST_ADDR: begin
                        addr_r <= addr_nxt;
                        cnt_r  <= cnt_r + 1'b1;
                        if (cnt_r == addr_len - 1'b1) begin
                            cnt_r   <= 5'h0_0;
                            data_r  <= 16'h0_000;
                            state_r <= ST_HOLD;
                            if (opc_r == secp_pkg::OPC_READ) begin
                                state_r           <= ST_READ; // [R3] [R12]
                                out_sr_r          <= fetch(word_org_r, addr_nxt);
                                serial_out_out    <= 1'b0; // [R4]
                                serial_out_oe_out <= 1'b1;
                            end else if (opc_r[2:0] == secp_pkg::OPC_PROGRAM_LOW) begin
                                state_r <= ST_DATA;
                                kind_r  <= secp_pkg::KIND_PROGRAM;
                            end else if (addr_nxt == 8'h00) begin
                                case (opc_r)
                                    secp_pkg::OPC_PROGRAM_EN: begin
                                        prog_en_r <= 1'b1; // [R10]
                                    end
                                    secp_pkg::OPC_PROGRAM_DIS: begin
                                        prog_en_r <= 1'b0; // [R11]
                                    end
                                    secp_pkg::OPC_ERASE_ALL: begin
                                        cmd_valid_r <= prog_en_r; // [R13]
                                        cmd_r       <= '{word_org_r, secp_pkg::KIND_ERASE_ALL, 8'h00, 16'h0_000};
                                    end
                                    secp_pkg::OPC_WRITE_ALL: begin
                                        state_r <= ST_DATA; // [R14]
                                        kind_r  <= secp_pkg::KIND_WRITE_ALL;
                                    end
                                    default: begin
                                        state_r <= ST_HOLD;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_DATA: begin
                        data_r <= data_nxt;
                        cnt_r  <= cnt_r + 1'b1;
                        if (cnt_r == data_len - 1'b1) begin
                            state_r     <= ST_HOLD;
                            cmd_valid_r <= prog_en_r; // [R10] [R11]
                            cmd_r       <= '{word_org_r, kind_r, addr_r, data_nxt};
                        end
                    end
                    ST_READ: begin
                        serial_out_out <= out_sr_r[15]; // [R4] [R5]
                        out_sr_r       <= {out_sr_r[14:0], 1'b0};
                    end
                    default: begin
                        state_r <= ST_HOLD;
                    end
                endcase
            end
        end
    end

    assign fill_if.valid   = cmd_valid_r;
    assign fill_if.payload = cmd_r;

    secp_cmd_buffer #(
        .WIDTH (secp_pkg::CMD_BITS),
        .DEPTH (2)
    ) u_buffer (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .up        (fill_if.sink),
        .dn        (drain_if.source)
    );

    // ------------------------------------------------------------
    // Self-timed executor
    // ------------------------------------------------------------
    secp_exec_e                    ex_state_r;
    secp_pkg::secp_cmd_s           ex_cmd_r;
    logic [7:0]                    ex_idx_r;
    logic [7:0]                    ex_last_r;
    logic [secp_pkg::TIMER_BITS-1:0] timer_r;
    secp_pkg::secp_cmd_s           head;
    logic [7:0]                    ex_byte;

    assign head           = secp_pkg::secp_cmd_s'(drain_if.payload);
    assign drain_if.ready = (ex_state_r == EX_IDLE);
    assign ex_byte        = (ex_cmd_r.word_org && !ex_idx_r[0]) ? ex_cmd_r.data[15:8] : ex_cmd_r.data[7:0];

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ex_state_r <= EX_IDLE;
            ex_cmd_r   <= '0;
            ex_idx_r   <= 8'h00;
            ex_last_r  <= 8'h00;
            timer_r    <= '0;
        end else begin
            case (ex_state_r)
                EX_IDLE: begin
                    if (drain_if.valid) begin
                        ex_state_r <= EX_SWEEP; // [R7]
                        ex_cmd_r   <= head;
                        timer_r    <= '0;
                        if (head.kind != secp_pkg::KIND_PROGRAM) begin
                            ex_idx_r  <= 8'h00;
                            ex_last_r <= 8'hFF;
                        end else if (head.word_org) begin
                            ex_idx_r  <= {head.addr[6:0], 1'b0};
                            ex_last_r <= {head.addr[6:0], 1'b1};
                        end else begin
                            ex_idx_r  <= head.addr;
                            ex_last_r <= head.addr;
                        end
                    end
                end
                EX_SWEEP: begin
                    timer_r  <= timer_r + 1'b1;
                    ex_idx_r <= ex_idx_r + 1'b1;
                    if (ex_idx_r == ex_last_r) begin
                        ex_state_r <= EX_WAIT;
                    end
                end
                EX_WAIT: begin
                    timer_r <= timer_r + 1'b1;
                    if (timer_r >= secp_pkg::TIMER_BITS'(PROG_CYCLES - 1)) begin
                        ex_state_r <= EX_IDLE; // [R8] [R16]
                    end
                end
                default: begin
                    ex_state_r <= EX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (ex_state_r == EX_SWEEP) begin
            case (ex_cmd_r.kind)
                secp_pkg::KIND_PROGRAM: begin
                    mem_r[ex_idx_r] <= secp_pkg::ERASED_BYTE & ex_byte; // [R7] [R9]
                end
                secp_pkg::KIND_ERASE_ALL: begin
                    mem_r[ex_idx_r] <= secp_pkg::ERASED_BYTE; // [R13]
                end
                secp_pkg::KIND_WRITE_ALL: begin
                    mem_r[ex_idx_r] <= mem_r[ex_idx_r] & ex_byte; // [R14] [R15]
                end
                default: begin
                    mem_r[ex_idx_r] <= mem_r[ex_idx_r];
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Ready status
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ready_out <= 1'b1;
        end else begin
            ready_out <= (ex_state_r == EX_IDLE) && !drain_if.valid && !cmd_valid_r; // [R8] [R16]
        end
    end
endmodule

// ### testbench/secp_host_model.sv
`timescale 1ns/100ps
module secp_host_model (
    // Clock
    input  wire logic clk_in,
    // Device pins
    input  wire logic serial_out_in,
    output logic      chip_select_out,
    output logic      serial_clk_out,
    output logic      serial_data_out
);
    initial begin
        chip_select_out = 1'b0;
        serial_clk_out  = 1'b0;
        serial_data_out = 1'b0;
    end

    // ------------------------------------------------------------
    // One framed instruction, six cycles per clock phase
    // ------------------------------------------------------------
    task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] rd);
        rd = 32'h0000_0000;
        @(posedge clk_in);
        #1 chip_select_out = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_out = v[i];
            repeat (6) @(posedge clk_in);
            #1 serial_clk_out = 1'b1;
            repeat (6) @(posedge clk_in);
            #1 rd = {rd[30:0], serial_out_in};
            serial_clk_out = 1'b0;
        end
        repeat (6) @(posedge clk_in);
        #1 chip_select_out = 1'b0;
        serial_data_out = ~serial_data_out;
        repeat (8) @(posedge clk_in);
        #1;
    endtask
endmodule

// ### testbench/secp_assertions.sv
`timescale 1ns/100ps
module secp_assertions #(
    parameter int PROG_CYCLES = 300
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Pins
    input wire logic chip_select_in,
    input wire logic serial_clk_in,
    input wire logic serial_in,
    input wire logic serial_out_out,
    input wire logic serial_out_oe_out,
    input wire logic organisation_strap_in,
    input wire logic ready_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    int low_cnt_r;
    int cs_low_cnt_r;

    always_ff @(posedge clk_in) begin
        if (!resetn_in || ready_out) begin
            low_cnt_r <= 0;
        end else begin
            low_cnt_r <= low_cnt_r + 1;
        end
    end

    // Cycles in a row that chip select has been low
    always_ff @(posedge clk_in) begin
        if (!resetn_in || chip_select_in) begin
            cs_low_cnt_r <= 0;
        end else if (cs_low_cnt_r < 255) begin
            cs_low_cnt_r <= cs_low_cnt_r + 1;
        end
    end

    reset_state_a: assert property (disable iff (1'b0) !resetn_in |=> ready_out && !serial_out_oe_out)
        else $error("outputs wrong after reset");
    oe_idle_off_a: assert property (!chip_select_in [*5] |-> !serial_out_oe_out)
        else $error("output enabled without chip select");
    out_edge_high_a: assert property ($changed(serial_out_out) && serial_out_oe_out |-> serial_clk_in)
        else $error("serial output changed while clock low");
    dummy_zero_a: assert property ($rose(serial_out_oe_out) |-> !serial_out_out)
        else $error("dummy bit not zero");
    oe_in_frame_a: assert property ($rose(serial_out_oe_out) |-> chip_select_in && serial_clk_in)
        else $error("output enabled outside a read frame");
    busy_min_a: assert property ($rose(ready_out) |-> low_cnt_r >= PROG_CYCLES)
        else $error("busy period too short");
    busy_max_a: assert property (low_cnt_r <= 2 * PROG_CYCLES + 40)
        else $error("busy period too long");
    ready_framed_a: assert property (!chip_select_in && cs_low_cnt_r >= 9 |-> !$fell(ready_out))
        else $error("busy without an instruction");

    cover property ($rose(serial_out_oe_out));
    cover property ($fell(ready_out));
    cover property (!ready_out && low_cnt_r == PROG_CYCLES);
endmodule

bind secp_command_port secp_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_secp_assertions (
    .clk_in(clk_in), .resetn_in(resetn_in), .chip_select_in(chip_select_in),
    .serial_clk_in(serial_clk_in), .serial_in(serial_in), .serial_out_out(serial_out_out),
    .serial_out_oe_out(serial_out_oe_out), .organisation_strap_in(organisation_strap_in),
    .ready_out(ready_out));

// ### testbench/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
    localparam int PROG = 300;
    logic        clk_in, resetn_in, strap, cs, sclk, din, dout, doe, ready, en;
    logic [7:0]  r;
    logic [31:0] rd;
    int          n_errors, compares, cycles, busy, a1, a2, am;
    int          mem [256];

    secp_command_port #(.PROG_CYCLES(PROG)) i_secp_command_port (.clk_in(clk_in), .resetn_in(resetn_in),
        .chip_select_in(cs), .serial_clk_in(sclk), .serial_in(din), .serial_out_out(dout),
        .serial_out_oe_out(doe), .organisation_strap_in(strap), .ready_out(ready));
    secp_host_model i_host (.clk_in(clk_in), .serial_out_in(doe ? dout : ~dout), .chip_select_out(cs),
        .serial_clk_out(sclk), .serial_data_out(din));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------
    function automatic int dw();
        return strap ? secp_pkg::WORD_DATA_BITS : secp_pkg::BYTE_DATA_BITS;
    endfunction

    function automatic int rnd();
        r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
        return strap ? (r * 256 + (r ^ 8'hA5)) : r;
    endfunction

    task automatic cmd(input logic [3:0] op, input int a, input int d, input int nd);
        int na;
        na = strap ? secp_pkg::WORD_ADDR_BITS : secp_pkg::BYTE_ADDR_BITS;
        i_host.xfer(7 + na + nd, ((((32'h1 << 4) | op) << na | a) << nd) | d, rd);
    endtask

    task automatic prog(input logic [3:0] op, input int a, input int d);
        cmd(op, a, d, dw());
        if (en && strap) begin
            mem[2 * a] = d >> 8;
            mem[2 * a + 1] = d & 255;
        end else if (en) begin
            mem[a] = d;
        end
        `CHK(ready, !en)
    endtask

    task automatic bulk(input logic [3:0] op, input int d);
        cmd(op, 0, d, (op == secp_pkg::OPC_WRITE_ALL) ? dw() : 0);
        for (int i = 0; i < 256; i++) begin
            if (en) mem[i] = (op == secp_pkg::OPC_ERASE_ALL) ? 255 : mem[i] & (strap ? (i % 2 ? d & 255 : d >> 8) : d);
        end
        `CHK(ready, !en)
    endtask

    task automatic wait_ready(input int min);
        busy = 0;
        while (ready !== 1'b1 && busy < 4 * PROG) begin
            @(posedge clk_in);
            #1 busy++;
        end
        `CHK(busy >= min, 1'b1)
        `CHK(ready, 1'b1)
    endtask

    task automatic rdchk(input int a);
        int e;
        e = strap ? (mem[2 * a] << 8) | mem[2 * a + 1] : mem[a];
        cmd(secp_pkg::OPC_READ, a, 0, dw());
        `CHK(rd & ((32'h1 << (dw() + 1)) - 1), e)
        `CHK(doe, 1'b0)
    endtask

    task automatic do_reset();
        @(posedge clk_in);
        #1 resetn_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1 en = 1'b0;
        `CHK({ready, doe, dout}, 3'b100)
    endtask

    task automatic results();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence, both organisations
    // ------------------------------------------------------------
    initial begin
        resetn_in = 1'b0;
        strap = 1'b0;
        en = 1'b0;
        r = 8'h5F;
        do_reset();
        prog(4'h4, 3, 8'h3C);
        for (int o = 0; o < 2; o++) begin
            strap = o[0];
            am = o ? 127 : 255;
            cmd(secp_pkg::OPC_PROGRAM_EN, 0, 0, 0);
            en = 1'b1;
            bulk(secp_pkg::OPC_ERASE_ALL, 0);
            wait_ready(PROG - 40);
            rdchk(rnd() & am);
            bulk(secp_pkg::OPC_WRITE_ALL, rnd());
            wait_ready(PROG - 40);
            a1 = rnd() & am;
            a2 = (a1 + 1) & am;
            rdchk(a1);
            prog(4'h4, a1, rnd());
            prog(4'hC, a2, rnd());
            wait_ready(PROG / 2);
            rdchk(a1);
            rdchk(a2);
            prog(4'h4, a1, (1 << dw()) - 1);
            wait_ready(PROG - 40);
            rdchk(a1);
            i_host.xfer(3, 32'h0000_0006, rd);
            rdchk(a2);
            cmd(secp_pkg::OPC_PROGRAM_DIS, 0, 0, 0);
            en = 1'b0;
            cmd(secp_pkg::OPC_PROGRAM_EN, 1, 0, 0);
            prog(4'h4, a2, 0);
            bulk(secp_pkg::OPC_ERASE_ALL, 0);
            bulk(secp_pkg::OPC_WRITE_ALL, 0);
            rdchk(a2);
        end
        strap = 1'b0;
        rdchk(2 * a2);
        do_reset();
        prog(4'h4, a1, 0);
        rdchk(a1);
        results();
    end
endmodule
